// ==== inc/gpp_defines.svh ====
// Register addresses, field positions, reset values and sizes of the pin port.
`ifndef GPP_DEFINES_SVH
`define GPP_DEFINES_SVH

`define GPP_ADDR_ENABLE 32'h01B0_0000
`define GPP_ADDR_DIRECTION 32'h01B0_0004
`define GPP_ADDR_VALUE 32'h01B0_0008
`define GPP_ADDR_RISE_FLAGS 32'h01B0_0010
`define GPP_ADDR_RISE_MASK 32'h01B0_0014
`define GPP_ADDR_FALL_FLAGS 32'h01B0_0018
`define GPP_ADDR_FALL_MASK 32'h01B0_001C
`define GPP_ADDR_GLOBAL_CTRL 32'h01B0_0020
`define GPP_ADDR_POLARITY 32'h01B0_0024
`define GPP_ADDR_IRQ_STATUS 32'h01B0_0030
`define GPP_ADDR_IRQ_CLEAR 32'h01B0_0034
`define GPP_ADDR_IRQ_ENABLE 32'h01B0_0038

`define GPP_GC_MODE_BIT 0
`define GPP_GC_AND_BIT 1

`define GPP_PIN_COUNT 16
`define GPP_IRQ_BITS 3

`define GPP_ENABLE_RST 32'h0000_0000
`define GPP_DIRECTION_RST 32'h0000_0000
`define GPP_VALUE_RST 32'h0000_0000
`define GPP_MASK_RST 32'h0000_0000
`define GPP_POLARITY_RST 32'h0000_0000

`endif

// ==== inc/gpp_pkg.sv ====
// Types shared by the pin port modules.
package gpp_pkg;

  typedef enum logic {
    GPP_MODE_DELTA,
    GPP_MODE_LOGIC
  } gpp_mode_t;

  // Bit 0 is the mode, bit 1 selects AND instead of OR in logic mode.
  typedef struct packed {
    logic logic_and;
    gpp_mode_t mode;
  } gpp_gctrl_t;

  // Bit 0 is the selected pin event, bits 1 and 2 any rise and any fall.
  typedef struct packed {
    logic fall_any;
    logic rise_any;
    logic pin_event;
  } gpp_evt_t;

endpackage

// ==== core/gpp_edge_detect.sv ====
// Per-pin rising and falling transition detector on sampled levels.
module gpp_edge_detect #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Levels and the pins allowed to report.
  input wire logic [W-1:0] lvl,
  input wire logic [W-1:0] arm,
  // One-cycle transition pulses.
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] prev_q;

  if (W < 1) begin : g_chk
    $error("gpp_edge_detect needs at least one pin");
  end

  // The history follows disarmed pins too, so arming a pin never reports
  // a stale transition.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= '0;
    end else begin
      prev_q <= lvl;
    end
  end

  assign rise = lvl & ~prev_q & arm;
  assign fall = ~lvl & prev_q & arm;

  edge_exclusive_a: assert property (
    @(posedge pclk) disable iff (!presetn) (rise & fall) == '0)
    else $error("rise and fall reported together");

endmodule // gpp_edge_detect

// ==== core/gpp_irq_ctrl.sv ====
// Sticky interrupt status with write-one clear, enable and level output.
`include "gpp_defines.svh"

module gpp_irq_ctrl (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Events from the port.
  input wire gpp_pkg::gpp_evt_t evt,
  // Register writes.
  input wire logic clr_wr,
  input wire logic en_wr,
  input wire logic [`GPP_IRQ_BITS-1:0] wdata,
  // State and interrupt line.
  output logic [`GPP_IRQ_BITS-1:0] status,
  output logic [`GPP_IRQ_BITS-1:0] enable,
  output logic irq
);

  logic [`GPP_IRQ_BITS-1:0] status_q;
  logic [`GPP_IRQ_BITS-1:0] status_d;
  logic [`GPP_IRQ_BITS-1:0] enable_q;
  logic [`GPP_IRQ_BITS-1:0] enable_d;
  logic [`GPP_IRQ_BITS-1:0] clr_bits;
  logic irq_q;

  assign clr_bits = clr_wr ? wdata : '0;
  // A new event wins over a clear in the same cycle.
  assign status_d = (status_q & ~clr_bits) | evt;
  assign enable_d = en_wr ? wdata : enable_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
      enable_q <= '0;
      irq_q <= 1'h0;
    end else begin
      status_q <= status_d;
      enable_q <= enable_d;
      irq_q <= |(status_d & enable_d);
    end
  end

  assign status = status_q;
  assign enable = enable_q;
  assign irq = irq_q;

  irq_level_a: assert property (
    @(posedge pclk) disable iff (!presetn) irq == |(status_q & enable_q))
    else $error("interrupt line disagrees with enabled status");

  set_wins_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (evt[0] && clr_wr && wdata[0]) |=> status_q[0])
    else $error("event lost against a clear");

endmodule // gpp_irq_ctrl

// ==== core/gpp_port.sv ====
// Sixteen-pin general-purpose port with APB registers, events and interrupt.
`include "gpp_defines.svh"

// Overview of operation
// - The port has sixteen pins, each with its own enable and direction bit.
// - A pin drives an output or reports input events only while its enable bit is 1.
// - On an enabled pin, direction 0 makes it an input and 1 an output.
// - With the enable bit clear, the direction bit has no effect on the pin.
// - An output pin drives the level software wrote into the value register.
// - Reading the value register returns the live level of each input pin.
// - Pin activity raises interrupts and DMA events in selectable modes.
// - After reset every pin is an input, with all direction bits at zero.
module gpp_port #(
  parameter int PINS = `GPP_PIN_COUNT
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // General pins.
  input wire logic [PINS-1:0] gp_in,
  output logic [PINS-1:0] gp_out,
  output logic [PINS-1:0] gp_oe,
  // Interrupt and DMA event.
  output logic cpu_irq,
  output logic dma_event
);

  if (PINS < 1 || PINS > `GPP_PIN_COUNT) begin : g_chk
    $error("gpp_port supports one to sixteen pins");
  end

  function automatic logic [31:0] zext(input logic [PINS-1:0] v);
    zext = {{(32-PINS){1'b0}}, v};
  endfunction

  logic [PINS-1:0] en_q;
  logic [PINS-1:0] dir_q;
  logic [PINS-1:0] out_q;
  logic [PINS-1:0] rise_flags_q;
  logic [PINS-1:0] rise_mask_q;
  logic [PINS-1:0] fall_flags_q;
  logic [PINS-1:0] fall_mask_q;
  logic [PINS-1:0] pol_q;
  logic [PINS-1:0] in_q;
  logic [PINS-1:0] oe_q;
  gpp_pkg::gpp_gctrl_t gctrl_q;
  logic logic_q;
  logic dma_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic seen_q;

  // Bus phase and address decode.
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_q;
  wire wr = access & pwrite;
  wire hit_en = paddr == `GPP_ADDR_ENABLE;
  wire hit_dir = paddr == `GPP_ADDR_DIRECTION;
  wire hit_val = paddr == `GPP_ADDR_VALUE;
  wire hit_rf = paddr == `GPP_ADDR_RISE_FLAGS;
  wire hit_rm = paddr == `GPP_ADDR_RISE_MASK;
  wire hit_ff = paddr == `GPP_ADDR_FALL_FLAGS;
  wire hit_fm = paddr == `GPP_ADDR_FALL_MASK;
  wire hit_gc = paddr == `GPP_ADDR_GLOBAL_CTRL;
  wire hit_pol = paddr == `GPP_ADDR_POLARITY;
  wire hit_ist = paddr == `GPP_ADDR_IRQ_STATUS;
  wire hit_icl = paddr == `GPP_ADDR_IRQ_CLEAR;
  wire hit_ien = paddr == `GPP_ADDR_IRQ_ENABLE;
  wire mapped = hit_en | hit_dir | hit_val | hit_rf | hit_rm | hit_ff |
                hit_fm | hit_gc | hit_pol | hit_ist | hit_icl | hit_ien;
  wire [PINS-1:0] wbits = pwdata[PINS-1:0];

  // Pin configuration: a set direction bit only counts on an enabled pin.
  wire [PINS-1:0] out_mask = en_q & dir_q;
  wire [PINS-1:0] in_arm = en_q & ~dir_q;
  wire [PINS-1:0] pin_read = (out_q & out_mask) | (in_q & ~out_mask);

  // Polarity turns each level round before detection.
  wire [PINS-1:0] lvl = in_q ^ pol_q;
  logic [PINS-1:0] rise;
  logic [PINS-1:0] fall;

  gpp_edge_detect #(
    .W(PINS)
  ) u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .lvl(lvl),
    .arm(in_arm),
    .rise(rise),
    .fall(fall)
  );

  // Logic mode combines the masked levels; an event is its rising edge.
  wire logic_or = |(lvl & rise_mask_q & in_arm);
  wire logic_and = &(lvl | ~(rise_mask_q & in_arm));
  wire logic_lvl = gctrl_q.logic_and ? logic_and : logic_or;
  wire delta_evt = |((rise & rise_mask_q) | (fall & fall_mask_q));
  wire logic_evt = logic_lvl & ~logic_q;
  wire pin_event = (gctrl_q.mode == gpp_pkg::GPP_MODE_LOGIC) ?
                   logic_evt : delta_evt;

  gpp_pkg::gpp_evt_t evt;
  assign evt.pin_event = pin_event;
  assign evt.rise_any = |rise;
  assign evt.fall_any = |fall;

  // Flags: a new edge wins over a write-one clear in the same cycle.
  wire [PINS-1:0] rise_clr = (wr & hit_rf) ? wbits : '0;
  wire [PINS-1:0] fall_clr = (wr & hit_ff) ? wbits : '0;
  wire [PINS-1:0] rise_flags_d = (rise_flags_q & ~rise_clr) | rise;
  wire [PINS-1:0] fall_flags_d = (fall_flags_q & ~fall_clr) | fall;

  logic [`GPP_IRQ_BITS-1:0] irq_status;
  logic [`GPP_IRQ_BITS-1:0] irq_enable;

  gpp_irq_ctrl u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .evt(evt),
    .clr_wr(wr & hit_icl),
    .en_wr(wr & hit_ien),
    .wdata(pwdata[`GPP_IRQ_BITS-1:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(cpu_irq)
  );

  // Read data selection; the clear register reads as zero.
  logic [31:0] rdata_d;
  always_comb begin
    if (hit_en) begin
      rdata_d = zext(en_q);
    end else if (hit_dir) begin
      rdata_d = zext(dir_q);
    end else if (hit_val) begin
      rdata_d = zext(pin_read);
    end else if (hit_rf) begin
      rdata_d = zext(rise_flags_q);
    end else if (hit_rm) begin
      rdata_d = zext(rise_mask_q);
    end else if (hit_ff) begin
      rdata_d = zext(fall_flags_q);
    end else if (hit_fm) begin
      rdata_d = zext(fall_mask_q);
    end else if (hit_gc) begin
      rdata_d = {30'h0000_0000, gctrl_q};
    end else if (hit_pol) begin
      rdata_d = zext(pol_q);
    end else if (hit_ist) begin
      rdata_d = {29'h0000_0000, irq_status};
    end else if (hit_ien) begin
      rdata_d = {29'h0000_0000, irq_enable};
    end else begin
      rdata_d = 32'h0000_0000;
    end
  end

  // Bus answer: ready in the first access cycle, data taken at setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        prdata_q <= rdata_d;
      end
    end
  end

  // Configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= PINS'(`GPP_ENABLE_RST);
      dir_q <= PINS'(`GPP_DIRECTION_RST);
      out_q <= PINS'(`GPP_VALUE_RST);
      rise_mask_q <= PINS'(`GPP_MASK_RST);
      fall_mask_q <= PINS'(`GPP_MASK_RST);
      pol_q <= PINS'(`GPP_POLARITY_RST);
      gctrl_q <= '0;
    end else if (wr) begin
      if (hit_en) en_q <= wbits;
      if (hit_dir) dir_q <= wbits;
      if (hit_val) out_q <= wbits;
      if (hit_rm) rise_mask_q <= wbits;
      if (hit_fm) fall_mask_q <= wbits;
      if (hit_pol) pol_q <= wbits;
      if (hit_gc) gctrl_q <= gpp_pkg::gpp_gctrl_t'(pwdata[1:0]);
    end
  end

  // Pin sampling, flags and event state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_q <= '0;
      oe_q <= '0;
      rise_flags_q <= '0;
      fall_flags_q <= '0;
      logic_q <= 1'h0;
      dma_q <= 1'h0;
      seen_q <= 1'h0;
    end else begin
      in_q <= gp_in;
      oe_q <= out_mask;
      rise_flags_q <= rise_flags_d;
      fall_flags_q <= fall_flags_d;
      logic_q <= logic_lvl;
      dma_q <= pin_event;
      seen_q <= 1'h1;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign gp_out = out_q;
  assign gp_oe = oe_q;
  assign dma_event = dma_q;

  apb_ready_a: assert property (
    @(posedge pclk) disable iff (!presetn) setup |=> pready)
    else $error("no ready in the first access cycle");

  enable_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr && hit_en) |=> en_q == $past(wbits))
    else $error("enable register did not take the write");

  disabled_quiet_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rise_flags_q & ~$past(rise_flags_q) & ~$past(in_arm)) == '0)
    else $error("flag set on a pin that is not an enabled input");

  drive_dir_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 gp_oe == $past(en_q & dir_q))
    else $error("output enable does not follow direction");

  dir_gated_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (gp_oe & ~$past(en_q)) == '0)
    else $error("disabled pin is driven");

  out_level_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr && hit_val) |=> ##1 gp_out == $past(wbits, 2))
    else $error("pin level does not follow the value write");

  read_level_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && hit_val) |=> prdata[PINS-1:0] == $past(pin_read))
    else $error("value read does not show the pin levels");

  event_out_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pin_event |=> dma_event && irq_status[0])
    else $error("pin event not passed on");

  reset_input_a: assert property (
    @(posedge pclk) disable iff (!presetn) !seen_q |-> dir_q == '0)
    else $error("direction not all input after reset");

  flag_latch_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((rise | fall) != '0) |=> ((rise_flags_q | fall_flags_q) &
                               $past(rise | fall)) == $past(rise | fall))
    else $error("transition not latched");

  cover_value_write_c: cover property (
    @(posedge pclk) disable iff (!presetn) wr && hit_val);
  cover_logic_event_c: cover property (
    @(posedge pclk) disable iff (!presetn)
    logic_evt && gctrl_q.mode == gpp_pkg::GPP_MODE_LOGIC);
  cover_irq_c: cover property (
    @(posedge pclk) disable iff (!presetn) $rose(cpu_irq));
  cover_slverr_c: cover property (
    @(posedge pclk) disable iff (!presetn) pslverr && access);

endmodule // gpp_port

// ==== verif/gpp_pin_partner.sv ====
// Far-side model of the devices wired to the general pins.
module gpp_pin_partner #(
  parameter int PINS = 16
) (
  // Levels the external devices want on each pin.
  input wire logic [PINS-1:0] ext_lvl,
  // Port side of the pins.
  input wire logic [PINS-1:0] gp_out,
  input wire logic [PINS-1:0] gp_oe,
  output logic [PINS-1:0] gp_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // External drivers back off where the port drives, so each wire resolves.
  assign gp_in = (gp_oe & gp_out) | (~gp_oe & ext_lvl);
endmodule // gpp_pin_partner

// ==== verif/gpp_port_tb_top.sv ====
// Self-checking bench for the sixteen-pin port driven over APB.
`include "gpp_defines.svh"
module gpp_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] gp_in;
  logic [15:0] gp_out;
  logic [15:0] gp_oe;
  logic [15:0] ext_lvl = 16'h0000;
  logic cpu_irq;
  logic dma_event;
  logic [31:0] rdat;
  logic rerr;
  int num_errors = 0;
  int n_checks = 0;
  int dma_cnt = 0;
  int dma_base = 0;

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (dma_event === 1'b1) dma_cnt <= dma_cnt + 1;
  end

  gpp_port #(.PINS(16)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gp_in(gp_in), .gp_out(gp_out),
    .gp_oe(gp_oe), .cpu_irq(cpu_irq), .dma_event(dma_event)
  );
  gpp_pin_partner #(.PINS(16)) pins (
    .ext_lvl(ext_lvl), .gp_out(gp_out), .gp_oe(gp_oe), .gp_in(gp_in)
  );

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      num_errors++;
      final_report();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string name, input logic [31:0] a,
                    input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0000_0000);
    check(name, exp, rdat);
    check({name, " error"}, {31'h0000_0000, exp_err}, {31'h0000_0000, rerr});
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge pclk);
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    check("gp_oe", 32'h0000_0000, {16'h0000, gp_oe});
    check("cpu_irq", 32'h0000_0000, {31'h0000_0000, cpu_irq});
    rd("enable", `GPP_ADDR_ENABLE, 32'h0000_0000, 1'b0);
    rd("direction", `GPP_ADDR_DIRECTION, 32'h0000_0000, 1'b0);
    rd("hole", 32'h01B0_000C, 32'h0000_0000, 1'b1);
    $display("reset test done");

    @(posedge pclk) ext_lvl <= 16'h3C3C;
    wr(`GPP_ADDR_ENABLE, 32'h0000_00FF);
    wr(`GPP_ADDR_DIRECTION, 32'h0000_0F0F);
    wr(`GPP_ADDR_VALUE, 32'h0000_A5A5);
    settle(2);
    check("gp_oe", 32'h0000_000F, {16'h0000, gp_oe});
    check("driven", 32'h0000_0005, {16'h0000, gp_out & gp_oe});
    rd("value", `GPP_ADDR_VALUE, 32'h0000_3C35, 1'b0);
    $display("direction test done");

    wr(`GPP_ADDR_DIRECTION, 32'h0000_0000);
    @(posedge pclk) ext_lvl <= 16'h0000;
    settle(4);
    wr(`GPP_ADDR_RISE_FLAGS, 32'h0000_FFFF);
    wr(`GPP_ADDR_FALL_FLAGS, 32'h0000_FFFF);
    wr(`GPP_ADDR_IRQ_CLEAR, 32'h0000_0007);
    wr(`GPP_ADDR_RISE_MASK, 32'h0000_0001);
    wr(`GPP_ADDR_FALL_MASK, 32'h0000_0001);
    wr(`GPP_ADDR_IRQ_ENABLE, 32'h0000_0007);
    settle(1);
    dma_base = dma_cnt;
    // Pin 8 is disabled, so only pin 0 may report.
    @(posedge pclk) ext_lvl <= 16'h0101;
    settle(6);
    check("cpu_irq", 32'h0000_0001, {31'h0000_0000, cpu_irq});
    check("dma count", 32'h0000_0001, 32'(dma_cnt - dma_base));
    rd("rise flags", `GPP_ADDR_RISE_FLAGS, 32'h0000_0001, 1'b0);
    rd("status", `GPP_ADDR_IRQ_STATUS, 32'h0000_0003, 1'b0);
    wr(`GPP_ADDR_IRQ_STATUS, 32'h0000_0000);
    rd("status ro", `GPP_ADDR_IRQ_STATUS, 32'h0000_0003, 1'b0);
    wr(`GPP_ADDR_IRQ_ENABLE, 32'h0000_0000);
    settle(2);
    check("masked irq", 32'h0000_0000, {31'h0000_0000, cpu_irq});
    wr(`GPP_ADDR_IRQ_CLEAR, 32'h0000_0003);
    rd("cleared", `GPP_ADDR_IRQ_STATUS, 32'h0000_0000, 1'b0);
    rd("clear reg", `GPP_ADDR_IRQ_CLEAR, 32'h0000_0000, 1'b0);
    wr(`GPP_ADDR_RISE_FLAGS, 32'h0000_0001);
    rd("rise clr", `GPP_ADDR_RISE_FLAGS, 32'h0000_0000, 1'b0);
    @(posedge pclk) ext_lvl <= 16'h0000;
    settle(6);
    rd("fall flags", `GPP_ADDR_FALL_FLAGS, 32'h0000_0001, 1'b0);
    rd("fall status", `GPP_ADDR_IRQ_STATUS, 32'h0000_0005, 1'b0);
    check("dma count", 32'h0000_0002, 32'(dma_cnt - dma_base));
    $display("delta event test done");

    // Logic mode: OR then AND over pins 0 and 1.
    wr(`GPP_ADDR_RISE_MASK, 32'h0000_0003);
    wr(`GPP_ADDR_GLOBAL_CTRL, 32'h0000_0001);
    wr(`GPP_ADDR_IRQ_CLEAR, 32'h0000_0007);
    @(posedge pclk) ext_lvl <= 16'h0002;
    settle(6);
    apb(1'b0, `GPP_ADDR_IRQ_STATUS, 32'h0000_0000);
    check("or event", 32'h0000_0001, rdat & 32'h0000_0001);
    wr(`GPP_ADDR_GLOBAL_CTRL, 32'h0000_0003);
    rd("global ctrl", `GPP_ADDR_GLOBAL_CTRL, 32'h0000_0003, 1'b0);
    wr(`GPP_ADDR_IRQ_CLEAR, 32'h0000_0007);
    @(posedge pclk) ext_lvl <= 16'h0003;
    settle(6);
    apb(1'b0, `GPP_ADDR_IRQ_STATUS, 32'h0000_0000);
    check("and event", 32'h0000_0001, rdat & 32'h0000_0001);
    $display("logic mode test done");

    // Inverting pin 0 while it sits high shows up as a falling edge.
    wr(`GPP_ADDR_GLOBAL_CTRL, 32'h0000_0000);
    wr(`GPP_ADDR_FALL_FLAGS, 32'h0000_FFFF);
    wr(`GPP_ADDR_IRQ_CLEAR, 32'h0000_0007);
    wr(`GPP_ADDR_POLARITY, 32'h0000_0001);
    settle(4);
    rd("polarity", `GPP_ADDR_POLARITY, 32'h0000_0001, 1'b0);
    rd("inverted fall", `GPP_ADDR_FALL_FLAGS, 32'h0000_0001, 1'b0);
    rd("inverted status", `GPP_ADDR_IRQ_STATUS, 32'h0000_0005, 1'b0);
    $display("polarity test done");
    final_report();
  end
endmodule // gpp_port_tb_top
